// [design/rfd_map.vh]
`ifndef RFD_MAP_VH
`define RFD_MAP_VH

// ==========================================================================
// register map
`define RFD_CTRL_ADDR 8'h00
`define RFD_STAT_ADDR 8'h04
`define RFD_CTRL_RST 10'h12B

// ==========================================================================
// control field positions and the status error bit
`define RFD_EN_BIT 0
`define RFD_FMODE_LSB 1
`define RFD_FCHAR_LSB 3
`define RFD_DMODE_LSB 5
`define RFD_RATE_BIT 7
`define RFD_CKSEL_LSB 8
`define RFD_CFGERR_BIT 4

// ==========================================================================
// three-level select codes
`define RFD_LVL_LOW 2'b00
`define RFD_LVL_MID 2'b01
`define RFD_LVL_HIGH 2'b10

// ==========================================================================
// framing patterns, first received bit in the msb
`define RFD_COMMA_NEG 8'h3E
`define RFD_COMMA_POS 8'hC1
`define RFD_K285_NEG 10'h0FA
`define RFD_K285_POS 10'h305

// ==========================================================================
// timing counts in bit periods; RFD_HIGH_RUN counts aligned hits
`define RFD_LAST_BIT 4'd9
`define RFD_HALF_CHAR 4'd5
`define RFD_MID_SPAN 6'd50
`define RFD_AGE_MAX 6'h3F
`define RFD_HIGH_RUN 3'd4
`define RFD_MAX_STRETCH 4'd2

// ==========================================================================
// receive status codes
`define RFD_ST_DATA 3'b000
`define RFD_ST_SPECIAL 3'b001
`define RFD_ST_FRAMING 3'b010
`define RFD_ST_NOSYNC 3'b011
`define RFD_ST_DISP 3'b101
`define RFD_ST_INVALID 3'b110

`endif

// [design/rfd_rx_framer.v]
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "rfd_map.vh"

// Operation
// - search every bit offset, then set boundaries
// - select chooses comma or full K28.5
// - comma compare uses eight bits
// - framer disabled keeps boundaries unchanged
// - enabled mode applies to all channels
// - low latency aligns on first detection by stretching
// - stretch at most two bits per cycle
// - framed output within nine or fourteen cycles
// - multi-byte modes shift data, not clock
// - mid mode needs two hits within 50 bits
// - high mode needs four consecutive aligned hits
// - decoder enabled converts characters back
// - status 000 data, 001 special
// - other status codes for framing, errors, sync
// - decoder off passes raw characters, clock select mid
// - special codes mapped per decoder mode
// - odd parity over each decoded character
// - channels run independent or bonded alike; here every lane frames on its own, with no bonded mode
module rfd_rx_framer #(
  parameter CHANNELS = 4
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [31:0] bus_rdata,
  input wire [CHANNELS-1:0] serial_in,
  output wire [CHANNELS*10-1:0] rx_char,
  output wire [CHANNELS*3-1:0] receive_char_status,
  output wire [CHANNELS-1:0] rx_parity,
  output wire [CHANNELS-1:0] rx_char_valid,
  output wire [CHANNELS-1:0] recovered_clock_out
);

  // ========================================================================
  // decode helpers
  // decoded value carries a valid flag in its msb; an unknown code returns zero
  function [5:0] dec6;
    input [5:0] c;
    begin
      case (c)
        6'b100111, 6'b011000: dec6 = {1'b1, 5'h00};
        6'b011101, 6'b100010: dec6 = {1'b1, 5'h01};
        6'b101101, 6'b010010: dec6 = {1'b1, 5'h02};
        6'b110001: dec6 = {1'b1, 5'h03};
        6'b110101, 6'b001010: dec6 = {1'b1, 5'h04};
        6'b101001: dec6 = {1'b1, 5'h05};
        6'b011001: dec6 = {1'b1, 5'h06};
        6'b111000, 6'b000111: dec6 = {1'b1, 5'h07};
        6'b111001, 6'b000110: dec6 = {1'b1, 5'h08};
        6'b100101: dec6 = {1'b1, 5'h09};
        6'b010101: dec6 = {1'b1, 5'h0A};
        6'b110100: dec6 = {1'b1, 5'h0B};
        6'b001101: dec6 = {1'b1, 5'h0C};
        6'b101100: dec6 = {1'b1, 5'h0D};
        6'b011100: dec6 = {1'b1, 5'h0E};
        6'b010111, 6'b101000: dec6 = {1'b1, 5'h0F};
        6'b011011, 6'b100100: dec6 = {1'b1, 5'h10};
        6'b100011: dec6 = {1'b1, 5'h11};
        6'b010011: dec6 = {1'b1, 5'h12};
        6'b110010: dec6 = {1'b1, 5'h13};
        6'b001011: dec6 = {1'b1, 5'h14};
        6'b101010: dec6 = {1'b1, 5'h15};
        6'b011010: dec6 = {1'b1, 5'h16};
        6'b111010, 6'b000101: dec6 = {1'b1, 5'h17};
        6'b110011, 6'b001100: dec6 = {1'b1, 5'h18};
        6'b100110: dec6 = {1'b1, 5'h19};
        6'b010110: dec6 = {1'b1, 5'h1A};
        6'b110110, 6'b001001: dec6 = {1'b1, 5'h1B};
        6'b001110, 6'b001111, 6'b110000: dec6 = {1'b1, 5'h1C};
        6'b101110, 6'b010001: dec6 = {1'b1, 5'h1D};
        6'b011110, 6'b100001: dec6 = {1'b1, 5'h1E};
        6'b101011, 6'b010100: dec6 = {1'b1, 5'h1F};
        default: dec6 = 6'h00;
      endcase
    end
  endfunction

  function [3:0] dec4;
    input [3:0] c;
    begin
      case (c)
        4'b1011, 4'b0100: dec4 = {1'b1, 3'd0};
        4'b1001: dec4 = {1'b1, 3'd1};
        4'b0101: dec4 = {1'b1, 3'd2};
        4'b1100, 4'b0011: dec4 = {1'b1, 3'd3};
        4'b1101, 4'b0010: dec4 = {1'b1, 3'd4};
        4'b1010: dec4 = {1'b1, 3'd5};
        4'b0110: dec4 = {1'b1, 3'd6};
        4'b1110, 4'b0001, 4'b0111, 4'b1000: dec4 = {1'b1, 3'd7};
        default: dec4 = 4'h0;
      endcase
    end
  endfunction

  // population counts feed the disparity check
  function [2:0] ones6;
    input [5:0] v;
    begin
      ones6 = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]}
        + {2'b00, v[3]} + {2'b00, v[4]} + {2'b00, v[5]};
    end
  endfunction

  // wraps a slip amount back into one character
  function [3:0] mod10;
    input [4:0] v;
    begin
      mod10 = (v >= 5'd10) ? v[3:0] - 4'd10 : v[3:0];
    end
  endfunction

  // ========================================================================
  // register port
  reg [9:0] ctrl_q;
  wire [CHANNELS-1:0] framed;
  wire fr_en = ctrl_q[`RFD_EN_BIT];
  wire [1:0] fr_mode = ctrl_q[`RFD_FMODE_LSB+1:`RFD_FMODE_LSB];
  wire [1:0] fr_char = ctrl_q[`RFD_FCHAR_LSB+1:`RFD_FCHAR_LSB];
  wire [1:0] dec_mode = ctrl_q[`RFD_DMODE_LSB+1:`RFD_DMODE_LSB];
  wire rate_half = ctrl_q[`RFD_RATE_BIT];
  wire [1:0] ck_sel = ctrl_q[`RFD_CKSEL_LSB+1:`RFD_CKSEL_LSB];
  // raw mode needs the per-channel recovered clock source
  wire cfg_err = (dec_mode == `RFD_LVL_LOW) && (ck_sel != `RFD_LVL_MID);

  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl_q <= `RFD_CTRL_RST;
      bus_rdata <= 32'h0000_0000;
    end
    else
    begin
      // modes are read live; a change acts from the next boundary found
      if (bus_wr && bus_addr == `RFD_CTRL_ADDR)
        ctrl_q <= bus_wdata[9:0];
      // read data stand for one cycle only and fall back to zero
      // the status word packs four framed flags; it assumes the default four lanes
      if (!bus_rd)
        bus_rdata <= 32'h0000_0000;
      else if (bus_addr == `RFD_CTRL_ADDR)
        bus_rdata <= {22'h000000, ctrl_q};
      else if (bus_addr == `RFD_STAT_ADDR)
        bus_rdata <= {27'h0000000, cfg_err, framed[3:0]};
      else
        bus_rdata <= 32'h0000_0000;
    end
  end

  // ========================================================================
  // per-channel framer and decoder; lanes share the config but each frames on its own
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : lane
      reg sync1_q, sync2_q;
      reg [18:0] hist_q;
      reg [3:0] bcnt_q, slip_q, stretch_q, ofs_q, last_ph_q;
      reg [5:0] age_q;
      reg [2:0] run_q;
      reg framed_q, rd_q, rclk_q, valid_q, par_q;
      reg [9:0] char_q;
      reg [2:0] stat_q;
      // nineteen bits of history plus the newest bit cover any offset
      wire [19:0] ext = {hist_q, sync2_q};
      wire [9:0] cur = ext[9:0];
      wire [19:0] ext_sh = ext >> ofs_q;
      wire [9:0] ten = ext_sh[9:0];
      // eighth comma bit is the inverse of the seventh
      wire comma_hit = (cur[9:2] == `RFD_COMMA_NEG) || (cur[9:2] == `RFD_COMMA_POS);
      wire k285_hit = (cur == `RFD_K285_NEG) || (cur == `RFD_K285_POS);
      wire hit_any = (fr_char == `RFD_LVL_HIGH) ? k285_hit
        : (fr_char == `RFD_LVL_MID) ? comma_hit : 1'b0;
      wire det = fr_en && hit_any;
      wire at_end = (bcnt_q == `RFD_LAST_BIT);
      wire cs = at_end && (stretch_q == 4'd0);
      wire [3:0] need = mod10({1'b0, bcnt_q} + {1'b0, ofs_q} + 5'd1);
      wire [3:0] new_ofs = `RFD_LAST_BIT - bcnt_q;
      // a hit on the offset already chosen only confirms framing
      wire in_phase = (new_ofs == ofs_q);
      // modes come from live control bits, shared by every lane
      wire mode_ll = (fr_mode == `RFD_LVL_LOW);
      wire mode_mid = (fr_mode == `RFD_LVL_MID);
      wire mode_hi = (fr_mode == `RFD_LVL_HIGH);
      wire same_ph = (last_ph_q == bcnt_q);
      wire mid_ok = det && mode_mid && same_ph && (age_q < `RFD_MID_SPAN);
      // a broken run restarts the count at one, the current hit itself
      wire run_next = det && same_ph && (age_q == 6'd9);
      wire [2:0] run_d = run_next ? run_q + 3'd1 : 3'd1;
      wire hi_ok = det && mode_hi && (run_d >= `RFD_HIGH_RUN);
      wire [5:0] d6 = dec6(ten[9:4]);
      // a positive-disparity K28 carries its 4-bit sub-block complemented,
      // so every such code is inverted before the shared 4-bit table;
      // no data code starts with 110000, so nothing else is touched
      wire flip4 = (ten[9:4] == 6'b110000);
      wire [3:0] d4 = dec4(flip4 ? ~ten[3:0] : ten[3:0]);
      wire alt7 = (ten[3:0] == 4'b0111) || (ten[3:0] == 4'b1000);
      wire k28 = (ten[9:4] == 6'b001111) || (ten[9:4] == 6'b110000);
      wire kx7 = alt7 && (d6[4:0] == 5'h17 || d6[4:0] == 5'h1B
        || d6[4:0] == 5'h1D || d6[4:0] == 5'h1E);
      wire is_k = k28 || kx7;
      wire is_frame = (ten[9:2] == `RFD_COMMA_NEG) || (ten[9:2] == `RFD_COMMA_POS);
      wire [7:0] byte_v = {d4[2:0], d6[4:0]};
      wire [2:0] n6 = ones6(ten[9:4]);
      wire [2:0] n4 = ones6({2'b00, ten[3:0]});
      reg rd_mid, rd_end, disp_err;
      reg [2:0] stat_d;

      // disparity is checked per sub-block; a wrong sign flags the character
      // but still resyncs the tracker to what was received
      always @*
      begin
        rd_mid = rd_q;
        disp_err = 1'b0;
        if (n6 > 3'd3)
        begin
          disp_err = rd_q;
          rd_mid = 1'b1;
        end
        else if (n6 < 3'd3)
        begin
          disp_err = ~rd_q;
          rd_mid = 1'b0;
        end
        rd_end = rd_mid;
        if (n4 > 3'd2)
        begin
          disp_err = disp_err | rd_mid;
          rd_end = 1'b1;
        end
        else if (n4 < 3'd2)
        begin
          disp_err = disp_err | ~rd_mid;
          rd_end = 1'b0;
        end
        // unsynced beats every other code, then invalid, disparity, framing
        if (!framed_q)
          stat_d = `RFD_ST_NOSYNC;
        else if (!d6[5] || !d4[3])
          stat_d = `RFD_ST_INVALID;
        else if (disp_err)
          stat_d = `RFD_ST_DISP;
        else if (is_frame && dec_mode == `RFD_LVL_MID)
          stat_d = `RFD_ST_FRAMING;
        else if (is_k)
          stat_d = `RFD_ST_SPECIAL;
        else
          stat_d = `RFD_ST_DATA;
      end

      always @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          sync1_q <= 1'b0;
          sync2_q <= 1'b0;
          hist_q <= 19'h00000;
          bcnt_q <= 4'h0;
          slip_q <= 4'h0;
          stretch_q <= 4'h0;
          ofs_q <= 4'h0;
          last_ph_q <= 4'h0;
          age_q <= `RFD_AGE_MAX;
          run_q <= 3'h0;
          framed_q <= 1'b0;
          // running disparity starts negative
          rd_q <= 1'b0;
          rclk_q <= 1'b0;
          valid_q <= 1'b0;
          par_q <= 1'b0;
          char_q <= 10'h000;
          stat_q <= `RFD_ST_NOSYNC;
        end
        else
        begin
          sync1_q <= serial_in[ch];
          sync2_q <= sync1_q;
          hist_q <= ext[18:0];
          // one valid pulse per character, a cycle after the boundary
          valid_q <= cs;
          // age saturates so a stale hit never meets the 50-bit window
          if (age_q != `RFD_AGE_MAX)
            age_q <= age_q + 6'd1;
          // character clock: end-of-character holds while a stretch is due
          if (at_end && stretch_q != 4'd0)
            stretch_q <= stretch_q - 4'd1;
          else if (at_end)
          begin
            // a detection may ask for up to nine bits of slip; it is paid
            // out two bits per character so the recovered clock never jumps
            bcnt_q <= 4'h0;
            if (slip_q > `RFD_MAX_STRETCH)
            begin
              stretch_q <= `RFD_MAX_STRETCH;
              slip_q <= slip_q - `RFD_MAX_STRETCH;
            end
            else
            begin
              stretch_q <= slip_q;
              slip_q <= 4'h0;
            end
          end
          else
            bcnt_q <= bcnt_q + 4'd1;
          if (det && !(at_end && stretch_q != 4'd0))
          begin
            last_ph_q <= bcnt_q;
            age_q <= 6'd0;
            run_q <= run_d;
            if (mode_ll && slip_q == 4'd0 && stretch_q == 4'd0)
            begin
              // first hit steers the clock itself
              slip_q <= need;
              framed_q <= (need == 4'd0);
            end
            else if ((mid_ok || hi_ok) && !in_phase)
            begin
              ofs_q <= new_ofs;
              framed_q <= 1'b1;
            end
            else if (!mode_ll && in_phase && (mid_ok || hi_ok))
              framed_q <= 1'b1;
          end
          else if (mode_ll && slip_q == 4'd0 && stretch_q == 4'd0 && at_end && det)
            framed_q <= framed_q;
          if (mode_ll && fr_en && !framed_q && slip_q == 4'd0 && stretch_q == 4'd0
            && age_q != `RFD_AGE_MAX && cs)
            framed_q <= 1'b1;
          // half rate toggles once per character, full rate is high half a character
          if (rate_half)
            rclk_q <= cs ? ~rclk_q : rclk_q;
          else
            rclk_q <= (bcnt_q < `RFD_HALF_CHAR);
          if (cs)
          begin
            if (dec_mode == `RFD_LVL_LOW)
            begin
              char_q <= ten;
              stat_q <= `RFD_ST_DATA;
              par_q <= ~^ten;
            end
            else
            begin
              // data decode is common to both enabled modes
              char_q <= {2'b00, byte_v};
              stat_q <= stat_d;
              par_q <= ~^byte_v;
              rd_q <= rd_end;
            end
          end
        end
      end

      assign framed[ch] = framed_q;
      assign rx_char[ch*10+9:ch*10] = char_q;
      assign receive_char_status[ch*3+2:ch*3] = stat_q;
      assign rx_parity[ch] = par_q;
      assign rx_char_valid[ch] = valid_q;
      assign recovered_clock_out[ch] = rclk_q;
    end
  endgenerate

endmodule

// [testbench/rfd_tx_model.sv]
`timescale 1ns/1ns
`include "rfd_map.vh"
// ==========================================================================
// far-side sender: 8b/10b characters, first bit first, disparity kept
module rfd_tx_model #(
  parameter LEAD = 3
) (
  input wire sys_clk,
  input wire rst_b,
  input wire comma_only,
  output wire ser_out
);
  reg [9:0] sh_q;
  reg [3:0] bit_q;
  reg [1:0] idx_q;
  reg [2:0] lead_q;
  reg idle_q;
  // alternating disparity so the stream never trips the disparity check
  function [9:0] pick(input [1:0] i);
    case (i)
      2'd0: pick = `RFD_K285_NEG;
      2'd2: pick = comma_only ? `RFD_K285_NEG : `RFD_K285_POS;
      default: pick = comma_only ? `RFD_K285_POS : 10'h2AA;
    endcase
  endfunction
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
    begin
      lead_q <= LEAD;
      bit_q <= 4'd9;
      idx_q <= 2'd3;
      sh_q <= 10'h000;
      idle_q <= 1'b0;
    end
    else if (lead_q != 3'd0)
    begin
      lead_q <= lead_q - 3'd1;
      idle_q <= ~idle_q;
    end
    else if (bit_q == 4'd9)
    begin
      sh_q <= pick(idx_q + 2'd1);
      idx_q <= idx_q + 2'd1;
      bit_q <= 4'd0;
    end
    else
    begin
      sh_q <= sh_q << 1;
      bit_q <= bit_q + 4'd1;
    end
  // the line toggles before the first character rather than resting at a level
  assign ser_out = (lead_q != 3'd0) ? idle_q : sh_q[9];
endmodule

// [testbench/rfd_rx_framer_props.sv]
`timescale 1ns/1ns
`include "rfd_map.vh"
module rfd_chk #(
  parameter CHANNELS = 4
) (
  input wire sys_clk,
  input wire rst_b,
  input wire [7:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire [CHANNELS*10-1:0] rx_char,
  input wire [CHANNELS*3-1:0] receive_char_status,
  input wire [CHANNELS-1:0] rx_parity,
  input wire [CHANNELS-1:0] rx_char_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // shadow of the control word, as software wrote it
  reg [9:0] ctrl_q;
  always @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      ctrl_q <= `RFD_CTRL_RST;
    else if (bus_wr && bus_addr == `RFD_CTRL_ADDR)
      ctrl_q <= bus_wdata[9:0];
  wire v = rx_char_valid[0];
  wire ll = ctrl_q[2:1] == `RFD_LVL_LOW;
  wire raw = ctrl_q[6:5] == `RFD_LVL_LOW;
  wire [2:0] st = receive_char_status[2:0];
  // ==========================================================================
  // assertions
  a_rd_idle: assert property (!$past(bus_rd) |-> bus_rdata == 32'h0)
    else $error("read data not idle");
  a_rd_unmapped: assert property (bus_rd && bus_addr != 8'h00 && bus_addr != 8'h04
    |=> bus_rdata == 32'h0) else $error("unmapped read not zero");
  a_rd_ctrl: assert property (bus_rd && bus_addr == 8'h00 |=> bus_rdata[9:0] == ctrl_q)
    else $error("control readback wrong");
  a_rd_cfg_err: assert property (bus_rd && bus_addr == 8'h04 |=> bus_rdata[31:5] == 27'h0
    && bus_rdata[4] == (raw && ctrl_q[9:8] != `RFD_LVL_MID)) else $error("status word wrong");
  a_valid_gap: assert property (v |=> !v [*8] ##1 !v)
    else $error("characters closer than ten bits");
  a_mb_period: assert property (v && !ll |-> ##10 v)
    else $error("character clock moved");
  a_ll_stretch: assert property (v && ll |-> ##[10:12] v)
    else $error("stretch beyond two bits");
  a_parity_odd: assert property (v && $past(ctrl_q, 12) == ctrl_q
    |-> ^{raw ? rx_char[9:0] : {2'b00, rx_char[7:0]}, rx_parity[0]}) else $error("parity even");
  a_raw_status: assert property (v && raw && $past(ctrl_q, 12) == ctrl_q |-> st == 3'b000)
    else $error("raw status not data");
  a_status_code: assert property (v |-> st != 3'b100 && st != 3'b111)
    else $error("undefined status code");
  a_alt_special: assert property (v && ctrl_q[6:5] == `RFD_LVL_HIGH
    && $past(ctrl_q, 12) == ctrl_q |-> st != 3'b010) else $error("comma not special");
endmodule
bind rfd_rx_framer rfd_chk #(.CHANNELS(CHANNELS)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .rx_char(rx_char), .receive_char_status(receive_char_status),
  .rx_parity(rx_parity), .rx_char_valid(rx_char_valid));

// [testbench/rfd_rx_framer_test.sv]
`timescale 1ns/1ns
`include "rfd_map.vh"
module rfd_rx_framer_test;
  reg sys_clk = 1'b0;
  reg rst_b = 1'b0;
  reg [7:0] bus_addr = 8'h00;
  reg [31:0] bus_wdata = 32'h0;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg comma_only = 1'b0;
  reg found;
  wire ser;
  wire [31:0] bus_rdata;
  wire [39:0] rx_char;
  wire [11:0] rx_st;
  wire [3:0] rx_parity;
  wire [3:0] valid;
  wire [3:0] rclk;
  integer err_total = 0;
  integer checks = 0;
  integer cyc = 0;
  rfd_tx_model u_tx (.sys_clk(sys_clk), .rst_b(rst_b), .comma_only(comma_only), .ser_out(ser));
  rfd_rx_framer u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .serial_in({4{ser}}), .rx_char(rx_char), .receive_char_status(rx_st),
    .rx_parity(rx_parity), .rx_char_valid(valid), .recovered_clock_out(rclk));
  initial
    forever #20 sys_clk = ~sys_clk;
  // ==========================================================================
  // shared tasks
  task check(input [8*5-1:0] nm, input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("wrong value %0s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    check("rdata", bus_rdata, exp);
  endtask
  task restart(input [9:0] c);
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    wr(`RFD_CTRL_ADDR, {22'h0, c});
  endtask
  // first and last channel must agree, as every channel sees the same stream
  task seek(input [2:0] st, input [9:0] ch, input [9:0] msk);
    found = 1'b0;
    repeat (60)
    begin
      @(posedge sys_clk);
      #1;
      if (valid[0] === 1'b1 && rx_st[2:0] === st && rx_st[11:9] === st
          && (rx_char[9:0] & msk) === ch && rx_char[39:30] === rx_char[9:0])
        found = 1'b1;
    end
    check("char", {31'h0, found}, 32'h1);
  endtask
  task frame_case(input [9:0] c, input [3:0] exp, input integer n);
    restart(c);
    repeat (n) @(posedge sys_clk);
    rd_chk(`RFD_STAT_ADDR, {28'h0, exp});
  endtask
  // steady character clock: a fixed number of level changes per 100 cycles
  task clk_case(input [9:0] c, input integer exp);
    integer n;
    reg prev;
    wr(`RFD_CTRL_ADDR, {22'h0, c});
    repeat (20) @(posedge sys_clk);
    #1;
    prev = rclk[3];
    n = 0;
    repeat (100)
    begin
      @(posedge sys_clk);
      #1;
      if (rclk[3] !== prev)
        n = n + 1;
      prev = rclk[3];
    end
    check("rclk", n, exp);
  endtask
  always @(posedge sys_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      err_total = err_total + 1;
      close_out;
    end
  end
  // ==========================================================================
  // test sequence
  initial
  begin
    restart(10'h12B);
    rd_chk(`RFD_CTRL_ADDR, 32'h12B);
    wr(8'h08, 32'h3FF);
    rd_chk(8'h08, 32'h0);
    rd_chk(`RFD_CTRL_ADDR, 32'h12B);
    repeat (400) @(posedge sys_clk);
    rd_chk(`RFD_STAT_ADDR, 32'hF);
    clk_case(10'h1AB, 10);
    clk_case(10'h12B, 20);
    $display("clock test done");
    seek(`RFD_ST_FRAMING, 10'h0BC, 10'h0FF);
    seek(`RFD_ST_DATA, 10'h0B5, 10'h0FF);
    wr(`RFD_CTRL_ADDR, 32'h14B);
    seek(`RFD_ST_SPECIAL, 10'h0BC, 10'h0FF);
    seek(`RFD_ST_DATA, 10'h0B5, 10'h0FF);
    $display("decode test done");
    wr(`RFD_CTRL_ADDR, 32'h10B);
    seek(`RFD_ST_DATA, `RFD_K285_NEG, 10'h3FF);
    seek(`RFD_ST_DATA, 10'h2AA, 10'h3FF);
    wr(`RFD_CTRL_ADDR, 32'h00B);
    rd_chk(`RFD_STAT_ADDR, 32'h1F);
    $display("raw test done");
    frame_case(10'h123, 4'h0, 300);
    frame_case(10'h133, 4'hF, 300);
    frame_case(10'h12A, 4'h0, 300);
    frame_case(10'h12D, 4'h0, 300);
    comma_only <= 1'b1;
    repeat (300) @(posedge sys_clk);
    rd_chk(`RFD_STAT_ADDR, 32'hF);
    frame_case(10'h129, 4'hF, 130);
    $display("framer test done");
    close_out;
  end
endmodule
